// ===== core/dlfs_status_regs.v
// fault and status registers with two-wire serial read port
`include "dlfs_defines.vh"
module dlfs_status_regs #(
  parameter OC_OFF_CYCLES = `DLFS_OC_OFF_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // serial link
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_n,
  // control bits from the control register
  input wire [1:0] output_on_bit,
  input wire [1:0] tone_transmit_bit,
  // analog sense comparators
  input wire main_supply_low,
  input wire internal_supply_low,
  input wire [1:0] overcurrent_sense,
  input wire overtemp_sense,
  input wire [1:0] pump_low_sense,
  input wire [1:0] out_beyond_wide,
  input wire [1:0] out_within_narrow,
  input wire [1:0] tone_seen_rx,
  input wire [1:0] tone_seen_tx,
  input wire factory_lock_sense,
  // outputs
  output reg irq_n,
  output reg [1:0] output_drive
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_ACK_ADDR = 3'h2;
  localparam S_WR = 3'h3;
  localparam S_ACK_WR = 3'h4;
  localparam S_RD = 3'h5;
  localparam S_ACK_RD = 3'h6;

  wire [16:0] syn;
  wire scl_s = syn[0];
  wire sda_s = syn[1];
  wire main_low_s = syn[2];
  wire int_low_s = syn[3];
  wire [1:0] oc_s = syn[5:4];
  wire ot_s = syn[6];
  wire [1:0] pump_low_s = syn[8:7];
  wire [1:0] wide_s = syn[10:9];
  wire [1:0] narrow_s = syn[12:11];
  wire [1:0] rx_s = syn[14:13];
  wire [1:0] tx_s = syn[16:15];

  dlfs_sync #(.W(17)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({tone_seen_tx, tone_seen_rx, out_within_narrow, out_beyond_wide,
      pump_low_sense, overtemp_sense, overcurrent_sense, internal_supply_low,
      main_supply_low, sda_in, scl_in}),
    .sync_out(syn)
  );

  // factory lock comes in through its own pair of flip-flops
  reg lock_meta_reg;
  reg lock_s_reg;

  reg scl_d_reg;
  reg sda_d_reg;
  reg [2:0] state_reg;
  reg [2:0] bitcnt_reg;
  reg done_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg rw_reg;
  reg ptr_reg;
  reg first_wr_reg;
  reg mack_reg;
  reg clear_reg;
  reg [3:0] shown_reg;

  reg sup_low_reg;
  reg [1:0] oc_reg;
  reg ot_reg;
  reg [1:0] off_reg;
  reg [1:0] pbad_reg;
  reg lock_reg;
  reg [22:0] oc_cnt0_reg;
  reg [22:0] oc_cnt1_reg;

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  wire [1:0] pump_good = ~pump_low_s;
  wire [1:0] tone_seen;
  assign tone_seen[0] = tone_transmit_bit[0] ? tx_s[0] : rx_s[0];
  assign tone_seen[1] = tone_transmit_bit[1] ? tx_s[1] : rx_s[1];

  wire [7:0] status_pri = {ot_reg, sup_low_reg, pbad_reg, oc_reg, off_reg};
  wire [7:0] status_sec = {3'h0, lock_reg, tone_seen, pump_good};

  // overcurrent timer reaches its limit
  function oc_expired;
    input [22:0] cnt;
    begin
      oc_expired = (cnt >= OC_OFF_CYCLES[22:0]);
    end
  endfunction

  wire [1:0] oc_trip = {oc_expired(oc_cnt1_reg), oc_expired(oc_cnt0_reg)};
  wire sup_low_now = main_low_s | int_low_s;

  // a flag is cleared only if the master saw it set in the acked byte
  wire clr_sup = clear_reg & shown_reg[0];
  wire [1:0] clr_oc = {clear_reg & shown_reg[2], clear_reg & shown_reg[1]};
  wire clr_ot = clear_reg & shown_reg[3];

  always @(posedge clk) begin
    if (rst) begin
      lock_meta_reg <= 1'b0;
      lock_s_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= S_IDLE;
      bitcnt_reg <= 3'h0;
      done_reg <= 1'b0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      ptr_reg <= 1'b0;
      first_wr_reg <= 1'b0;
      mack_reg <= 1'b0;
      clear_reg <= 1'b0;
      shown_reg <= 4'h0;
      sda_oe_n <= 1'b1;
    end else begin
      lock_meta_reg <= factory_lock_sense;
      lock_s_reg <= lock_meta_reg;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      clear_reg <= 1'b0;
      if (start_cond) begin
        state_reg <= S_ADDR;
        bitcnt_reg <= 3'h0;
        done_reg <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state_reg <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        case (state_reg)
          S_ADDR, S_WR, S_RD: begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bitcnt_reg <= bitcnt_reg + 3'h1;
            done_reg <= (bitcnt_reg == 3'h7);
          end
          S_ACK_RD: begin
            mack_reg <= ~sda_s;
            if (~sda_s) begin
              clear_reg <= ~ptr_reg;
              ptr_reg <= ~ptr_reg;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_reg)
          S_ADDR: begin
            if (done_reg) begin
              done_reg <= 1'b0;
              if (shift_reg[7:1] == `DLFS_SLAVE_ADDR) begin
                sda_oe_n <= 1'b0;
                rw_reg <= shift_reg[0];
                state_reg <= S_ACK_ADDR;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_ACK_ADDR: begin
            bitcnt_reg <= 3'h0;
            first_wr_reg <= 1'b1;
            if (rw_reg) begin
              tx_reg <= ptr_reg ? status_sec : status_pri;
              shown_reg <= {ot_reg, oc_reg, sup_low_reg};
              sda_oe_n <= ptr_reg ? status_sec[7] : status_pri[7];
              state_reg <= S_RD;
            end else begin
              sda_oe_n <= 1'b1;
              state_reg <= S_WR;
            end
          end
          S_WR: begin
            if (done_reg) begin
              done_reg <= 1'b0;
              sda_oe_n <= 1'b0;
              if (first_wr_reg) begin
                ptr_reg <= shift_reg[0];
              end
              first_wr_reg <= 1'b0;
              state_reg <= S_ACK_WR;
            end
          end
          S_ACK_WR: begin
            sda_oe_n <= 1'b1;
            state_reg <= S_WR;
          end
          S_RD: begin
            if (done_reg) begin
              done_reg <= 1'b0;
              sda_oe_n <= 1'b1;
              mack_reg <= 1'b0;
              state_reg <= S_ACK_RD;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_n <= tx_reg[6];
            end
          end
          S_ACK_RD: begin
            if (mack_reg) begin
              bitcnt_reg <= 3'h0;
              tx_reg <= ptr_reg ? status_sec : status_pri;
              shown_reg <= {ot_reg, oc_reg, sup_low_reg};
              sda_oe_n <= ptr_reg ? status_sec[7] : status_pri[7];
              state_reg <= S_RD;
            end else begin
              state_reg <= S_IDLE;
            end
          end
          default: begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;

  // fault latches, set wins over clear
  always @(posedge clk) begin
    if (rst) begin
      sup_low_reg <= `DLFS_RST_SUPLOW;
      oc_reg <= 2'h0;
      ot_reg <= 1'b0;
      lock_reg <= 1'b0;
      oc_cnt0_reg <= 23'h0;
      oc_cnt1_reg <= 23'h0;
      irq_n <= 1'b1;
      output_drive <= 2'h0;
    end else begin
      oc_cnt0_reg <= oc_s[0] ? (oc_trip[0] ? oc_cnt0_reg : oc_cnt0_reg + 23'h1) : 23'h0;
      oc_cnt1_reg <= oc_s[1] ? (oc_trip[1] ? oc_cnt1_reg : oc_cnt1_reg + 23'h1) : 23'h0;
      sup_low_reg <= sup_low_now | (sup_low_reg & ~clr_sup);
      oc_reg <= (oc_trip & oc_s) | (oc_reg & ~clr_oc);
      ot_reg <= ot_s | (ot_reg & ~clr_ot);
      if (lock_s_reg) begin
        lock_reg <= 1'b1;
      end
      irq_n <= ~(sup_low_reg | (|oc_reg) | ot_reg);
      output_drive <= ~off_reg;
    end
  end

  // output off flags and power bad hysteresis per output
  integer i;
  integer j;
  reg [1:0] fault_any;
  always @* begin
    for (i = 0; i < 2; i = i + 1) begin
      fault_any[i] = sup_low_now | sup_low_reg | ot_s | ot_reg
        | oc_reg[i] | (oc_trip[i] & oc_s[i]) | pump_low_s[i];
    end
  end

  always @(posedge clk) begin
    for (j = 0; j < 2; j = j + 1) begin
      if (rst) begin
        off_reg[j] <= 1'b1;
      end else if (fault_any[j] | ~output_on_bit[j]) begin
        off_reg[j] <= 1'b1;
      end else begin
        off_reg[j] <= 1'b0;
      end
      if (rst | off_reg[j]) begin
        pbad_reg[j] <= 1'b0;
      end else if (wide_s[j]) begin
        pbad_reg[j] <= 1'b1;
      end else if (narrow_s[j]) begin
        pbad_reg[j] <= 1'b0;
      end
    end
  end
endmodule

// ===== shared/dlfs_defines.vh
// constants for the dual supply fault and status register bank
`ifndef DLFS_DEFINES_VH
`define DLFS_DEFINES_VH

// serial register offsets
`define DLFS_REG_STATUS_PRI 8'h00
`define DLFS_REG_STATUS_SEC 8'h01

// primary status field positions
`define DLFS_PRI_OFF1 0
`define DLFS_PRI_OFF2 1
`define DLFS_PRI_OC1 2
`define DLFS_PRI_OC2 3
`define DLFS_PRI_PBAD1 4
`define DLFS_PRI_PBAD2 5
`define DLFS_PRI_SUPLOW 6
`define DLFS_PRI_OTEMP 7

// secondary status field positions
`define DLFS_SEC_PUMP1 0
`define DLFS_SEC_PUMP2 1
`define DLFS_SEC_TONE1 2
`define DLFS_SEC_TONE2 3
`define DLFS_SEC_LOCK 4

// slave address, value is arbitrary
`define DLFS_SLAVE_ADDR 7'h10

// timing
`define DLFS_CLK_MHZ 100
`define DLFS_OC_OFF_DELAY_MS 45
`define DLFS_OC_OFF_CYCLES (`DLFS_OC_OFF_DELAY_MS * 1000 * `DLFS_CLK_MHZ)

// reset values
`define DLFS_RST_SUPLOW 1'b1
`define DLFS_RST_OFF 2'h3

`endif

// ===== core/dlfs_sync.v
// two flip-flop synchroniser for asynchronous inputs
module dlfs_sync #(
  parameter W = 17
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // asynchronous side
  input wire [W-1:0] async_in,
  // synchronised side
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;

  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ===== tb/dlfs_props.sv
// checker for the fault and status register bank
module dlfs_props #(
  parameter OC_OFF_CYCLES = 20
) (
  // clock and reset
  input logic clk,
  input logic rst,
  // serial link
  input logic scl_in,
  input logic sda_in,
  input logic sda_oe_n,
  // control and sense
  input logic [1:0] output_on_bit,
  input logic main_supply_low,
  input logic internal_supply_low,
  input logic [1:0] overcurrent_sense,
  input logic overtemp_sense,
  input logic [1:0] pump_low_sense,
  // outputs
  input logic irq_n,
  input logic [1:0] output_drive
);
  int since_ack;
  int oc_run;
  logic fault_seen;
  wire any_fault = main_supply_low | internal_supply_low | overtemp_sense | (|overcurrent_sense);
  wire calm = output_on_bit[0] & ~any_fault & ~pump_low_sense[0] & irq_n;
  always @(posedge clk) begin
    if (rst) begin
      since_ack <= 99;
      oc_run <= 0;
      fault_seen <= 1'b0;
    end else begin
      since_ack <= (scl_in & ~sda_in & sda_oe_n) ? 0 : since_ack + 1;
      oc_run <= overcurrent_sense[1] ? oc_run + 1 : 0;
      fault_seen <= fault_seen | any_fault;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_calm;
    calm [*8];
  endsequence
  sequence s_hot;
    overtemp_sense [*5];
  endsequence
  enable_off_a: assert property (!output_on_bit[0] [*4] |-> !output_drive[0])
    else $error("output 1 driven with enable clear");
  supply_off_a: assert property ((main_supply_low | internal_supply_low) [*5]
    |-> output_drive == 2'h0 && !irq_n) else $error("supply low not reported");
  temp_off_a: assert property (s_hot |-> output_drive == 2'h0 && !irq_n)
    else $error("overtemperature not reported");
  pump_off_a: assert property (pump_low_sense[0] [*5] |-> !output_drive[0])
    else $error("output 1 driven with pump low");
  back_on_a: assert property (s_calm |-> output_drive[0])
    else $error("output 1 stays off");
  oc_off_a: assert property (oc_run > OC_OFF_CYCLES + 5 |-> !output_drive[1] && !irq_n)
    else $error("overcurrent not reported");
  irq_cause_a: assert property ($fell(irq_n) |-> $past(rst, 2) || fault_seen)
    else $error("interrupt without fault");
  irq_release_a: assert property ($rose(irq_n) |-> since_ack < 8)
    else $error("interrupt released without acknowledge");
  sda_change_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data changed while clock high");
endmodule
bind dlfs_status_regs dlfs_props #(.OC_OFF_CYCLES(OC_OFF_CYCLES)) i_props (.clk, .rst,
  .scl_in, .sda_in, .sda_oe_n, .output_on_bit, .main_supply_low, .internal_supply_low,
  .overcurrent_sense, .overtemp_sense, .pump_low_sense, .irq_n, .output_drive);

// ===== tb/dlfs_host.sv
// host model acting as two-wire serial master
module dlfs_host (
  // clock
  input logic clk,
  // serial link
  input logic sda_line,
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic q();
    repeat (4) @(negedge clk);
  endtask
  task automatic start();
    sda_m = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic bit_x(input logic d, output logic r);
    sda_m = d;
    q();
    scl = 1'b1;
    q();
    r = sda_line;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
  endtask
  task automatic read_reg(input logic [6:0] a, input logic p, output logic [7:0] d,
                          output logic nak);
    logic [7:0] r;
    logic k;
    start();
    byte_x({a, 1'b0}, r);
    bit_x(1'b1, nak);
    byte_x({7'h00, p}, r);
    bit_x(1'b1, k);
    start();
    byte_x({a, 1'b1}, r);
    bit_x(1'b1, k);
    byte_x(8'hFF, d);
    bit_x(1'b0, k);
    // the ack asks for one more byte; take it and end it with a nack
    byte_x(8'hFF, r);
    bit_x(1'b1, k);
    sda_m = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b1;
    q();
  endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the fault and status register bank
`include "dlfs_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OC = 20;
  logic clk, rst, scl, sda_m, sda_oe_n, sda_out, irq_n, nak;
  logic main_supply_low, internal_supply_low, overtemp_sense, factory_lock_sense;
  logic [1:0] output_on_bit, tone_transmit_bit, overcurrent_sense, pump_low_sense;
  logic [1:0] out_beyond_wide, out_within_narrow, tone_seen_rx, tone_seen_tx, output_drive;
  logic [7:0] got, e;
  wire sda_line = sda_m & (sda_oe_n | sda_out);
  int bad_count, samples_checked, cyc;
  dlfs_status_regs #(.OC_OFF_CYCLES(OC)) i_dut (.clk, .rst, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe_n, .output_on_bit, .tone_transmit_bit, .main_supply_low,
    .internal_supply_low, .overcurrent_sense, .overtemp_sense, .pump_low_sense,
    .out_beyond_wide, .out_within_narrow, .tone_seen_rx, .tone_seen_tx,
    .factory_lock_sense, .irq_n, .output_drive);
  dlfs_host i_host (.clk, .sda_line, .scl, .sda_m);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] g, input logic [7:0] x);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, g, x);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(input logic p, input logic [7:0] x);
    i_host.read_reg(`DLFS_SLAVE_ADDR, p, got, nak);
    check(got, x);
  endtask
  function automatic logic [7:0] exp_sec(input logic lk);
    return {3'h0, lk, tone_transmit_bit & tone_seen_tx | ~tone_transmit_bit & tone_seen_rx,
            ~pump_low_sense};
  endfunction
  initial begin
    {rst, output_on_bit, tone_transmit_bit, overcurrent_sense, pump_low_sense} = 9'h100;
    {main_supply_low, internal_supply_low, overtemp_sense, factory_lock_sense} = 4'h0;
    {out_beyond_wide, out_within_narrow, tone_seen_rx, tone_seen_tx} = 8'h30;
    void'($urandom(32'h7282a789));
    settle(16);
    rst = 1'b0;
    settle(8);
    check({7'h0, irq_n}, 8'h00);
    rd(0, 8'h43);
    check({7'h0, irq_n}, 8'h01);
    rd(0, 8'h03);
    for (int i = 0; i < 6; i++) begin
      {tone_transmit_bit, tone_seen_rx, tone_seen_tx, pump_low_sense} = 8'($urandom);
      factory_lock_sense = (i == 3);
      settle(8);
      factory_lock_sense = 1'b0;
      rd(1, exp_sec(i >= 3));
    end
    pump_low_sense = 2'h0;
    output_on_bit = 2'h3;
    settle(10);
    rd(0, 8'h00);
    {out_beyond_wide, out_within_narrow} = 4'h6;
    settle(8);
    rd(0, 8'h10);
    {out_beyond_wide, out_within_narrow} = 4'h0;
    settle(8);
    rd(0, 8'h10);
    out_within_narrow = 2'h3;
    settle(8);
    rd(0, 8'h00);
    for (int k = 0; k < 3; k++) begin
      {overtemp_sense, internal_supply_low, main_supply_low} = 3'(1 << k);
      settle(10);
      e = (k == 2) ? 8'h83 : 8'h43;
      rd(0, e);
      check({7'h0, irq_n}, 8'h00);
      {overtemp_sense, internal_supply_low, main_supply_low} = 3'h0;
      settle(8);
      rd(0, e);
      rd(0, 8'h00);
    end
    overcurrent_sense = 2'h2;
    settle(OC - 8);
    overcurrent_sense = 2'h0;
    settle(8);
    rd(0, 8'h00);
    overcurrent_sense = 2'h2;
    settle(OC + 8);
    overcurrent_sense = 2'h0;
    check({7'h0, irq_n}, 8'h00);
    output_on_bit = 2'h1;
    settle(4);
    output_on_bit = 2'h3;
    settle(8);
    rd(0, 8'h0A);
    rd(0, 8'h00);
    i_host.read_reg(7'h11, 1'b0, got, nak);
    check({7'h0, nak}, 8'h01);
    print_verdict();
  end
endmodule
